// File: src/ssap_defines.vh
`ifndef SSAP_DEFINES_VH
`define SSAP_DEFINES_VH

// Register byte addresses.
`define SSAP_ADDR_CLK 24'hFF4000
`define SSAP_ADDR_RXCTL 24'hFF4004
`define SSAP_ADDR_TXCTL 24'hFF4008
`define SSAP_ADDR_TXL 24'hFF400C
`define SSAP_ADDR_TXR 24'hFF4010
`define SSAP_ADDR_RXL 24'hFF4014
`define SSAP_ADDR_RXR 24'hFF4018
`define SSAP_ADDR_STAT 24'hFF401C

// Reset values.
`define SSAP_CLK_RST 32'h00070000
`define SSAP_CTL_RST 32'h0000001C

// Clock register fields.
`define SSAP_CLK_EN 0
`define SSAP_CLK_SEL 2:1
`define SSAP_CLK_MS 3
`define SSAP_CLK_DIV 15:8
`define SSAP_CLK_WORD_PHASE_LENGTH 20:16
`define SSAP_CLK_LOCKED 32'h001FFF06

// Receive and transmit control fields (shared layout; FENR, FENL and FILL are transmit only).
`define SSAP_CTL_MOD 1:0
`define SSAP_CTL_RES 6:2
`define SSAP_CTL_ER 7
`define SSAP_CTL_RI 8
`define SSAP_CTL_LI 9
`define SSAP_CTL_RD 10
`define SSAP_CTL_LD 11
`define SSAP_CTL_FENR 12
`define SSAP_CTL_FENL 13
`define SSAP_CTL_ALIGN 15:14
`define SSAP_CTL_THR 18:16
`define SSAP_CTL_FILL 22
`define SSAP_RXCTL_MASK 32'h0007CFFF
`define SSAP_TXCTL_MASK 32'h0047FFFF

// Status fields.
`define SSAP_ST_RXERR 0
`define SSAP_ST_TXERR 1

// Format codes.
`define SSAP_FMT_OFF 2'h0
`define SSAP_FMT_STD 2'h1
`define SSAP_FMT_LJ 2'h2
`define SSAP_FMT_RJ 2'h3

// Alignment codes.
`define SSAP_AL_HI24 2'h0
`define SSAP_AL_LO24 2'h1
`define SSAP_AL_16 2'h2
`define SSAP_AL_8 2'h3

// Clock source codes.
`define SSAP_SRC_BUS 2'h0
`define SSAP_SRC_AUX 2'h1

// Divider accumulator step in quarter source periods.
`define SSAP_DIV_STEP 9'h004

`define SSAP_FIFO_DEPTH 8

`endif

// File: src/ssap_fifo.v
`timescale 1ns/1ps
module ssap_fifo #(
  parameter W = 24,
  parameter AW = 3
) (
  input wire clk_i, // Clock.
  input wire rst_n_i, // Asynchronous reset, active low.
  input wire ce_i, // Clock enable.
  input wire push_i, // Write one word.
  input wire [W-1:0] wdata_i, // Word to write.
  input wire pop_i, // Drop the head word.
  output wire [W-1:0] head_o, // Head word.
  output wire full_o, // No free entry.
  output wire empty_o, // No stored entry.
  output wire [AW:0] count_o // Stored words.
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire do_push = push_i & ~full_o;
  wire do_pop = pop_i & ~empty_o;

  assign count_o = wp_q - rp_q;
  assign full_o = (count_o == (1 << AW));
  assign empty_o = (wp_q == rp_q);
  assign head_o = mem[rp_q[AW-1:0]];

  always @(posedge clk_i) begin
    if (ce_i && do_push) begin
      mem[wp_q[AW-1:0]] <= wdata_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // ssap_fifo

// File: src/ssap_top.v
`timescale 1ns/1ps
`include "ssap_defines.vh"
module ssap_top #(
  parameter AW = 3
) (
  input wire clk_i, // Bus clock, 40 MHz.
  input wire rst_n_i, // Asynchronous reset, active low.
  input wire ce_i, // Clock enable, freezes all state when low.
  input wire aux_tick_i, // Auxiliary clock source as a clock-enable pulse.
  input wire [23:0] addr_i, // Register byte address.
  input wire [31:0] wdata_i, // Write data.
  input wire wr_i, // Write strobe.
  input wire rd_i, // Read strobe.
  output reg [31:0] rdata_o, // Read data, valid the cycle after rd_i.
  input wire sck_i, // Bit clock from the pin.
  output reg sck_o, // Bit clock driven in master mode.
  output reg sck_oe_o, // Bit clock output enable.
  input wire ws_i, // Word select from the pin.
  output reg ws_o, // Word select driven in master mode.
  output reg ws_oe_o, // Word select output enable.
  input wire sdi_i, // Serial data in.
  output reg sdo_o, // Serial data out.
  output reg irq_o, // Combined interrupt request.
  output reg dma_rxl_o, // Receive left DMA request.
  output reg dma_rxr_o, // Receive right DMA request.
  output reg dma_txl_o, // Transmit left DMA request.
  output reg dma_txr_o // Transmit right DMA request.
);
  localparam DEPTH = `SSAP_FIFO_DEPTH;

  reg [31:0] clk_q;
  reg [31:0] rxc_q;
  reg [31:0] txc_q;
  reg rxerr_q;
  reg txerr_q;
  reg [8:0] acc_q;
  reg sck_q;
  reg ws_q;
  reg [4:0] wcnt_q;
  reg sck_prev_q;
  reg ws_last_q;
  reg [5:0] bit_q;
  reg [23:0] rx_sh_q;
  reg rx_left_q;
  reg rx_have_q;
  reg [23:0] tx_sh_q;
  reg [31:0] rdata_d;

  wire en = clk_q[`SSAP_CLK_EN];
  wire ms = clk_q[`SSAP_CLK_MS];
  wire [7:0] div = clk_q[`SSAP_CLK_DIV];
  wire [4:0] word_phase_length = clk_q[`SSAP_CLK_WORD_PHASE_LENGTH];
  wire [1:0] rx_fmt = rxc_q[`SSAP_CTL_MOD];
  wire [1:0] tx_fmt = txc_q[`SSAP_CTL_MOD];
  wire [4:0] rx_res = rxc_q[`SSAP_CTL_RES];
  wire [4:0] tx_res = txc_q[`SSAP_CTL_RES];
  wire fill = txc_q[`SSAP_CTL_FILL];
  wire run = ce_i & en;

  // FIFO ports.
  wire [23:0] rxl_head, rxr_head, txl_head, txr_head;
  wire rxl_full, rxr_full, txl_full, txr_full;
  wire rxl_empty, rxr_empty, txl_empty, txr_empty;
  wire [AW:0] rxl_cnt, rxr_cnt, txl_cnt, txr_cnt;

  // Register access decode.
  wire wr_clk = wr_i && (addr_i == `SSAP_ADDR_CLK);
  wire wr_rxc = wr_i && (addr_i == `SSAP_ADDR_RXCTL);
  wire wr_txc = wr_i && (addr_i == `SSAP_ADDR_TXCTL);
  wire wr_txl = wr_i && (addr_i == `SSAP_ADDR_TXL);
  wire wr_txr = wr_i && (addr_i == `SSAP_ADDR_TXR);
  wire wr_st = wr_i && (addr_i == `SSAP_ADDR_STAT);
  wire rd_rxl = rd_i && (addr_i == `SSAP_ADDR_RXL);
  wire rd_rxr = rd_i && (addr_i == `SSAP_ADDR_RXR);

  // Source tick selects the bus clock or the auxiliary clock.
  reg src_tick;
  always @* begin
    if (clk_q[`SSAP_CLK_SEL] == `SSAP_SRC_BUS) begin
      src_tick = 1'b1;
    end else if (clk_q[`SSAP_CLK_SEL] == `SSAP_SRC_AUX) begin
      src_tick = aux_tick_i;
    end else begin
      src_tick = 1'b0;
    end
  end

  // Bit clock divider. The accumulator counts quarter source periods so that a bit
  // clock half period of (div+1)/4 source periods comes out right on average; below
  // one source period per half it saturates at one toggle per tick.
  wire [8:0] acc_sum = acc_q + `SSAP_DIV_STEP;
  wire [8:0] div_p1 = {1'b0, div} + 9'h001;
  wire acc_hit = src_tick && (acc_sum >= div_p1);
  wire sck_fall_gen = acc_hit && sck_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= 9'h000;
      sck_q <= 1'b0;
      ws_q <= 1'b0;
      wcnt_q <= 5'h00;
    end else if (run && ms) begin
      if (acc_hit) begin
        acc_q <= (acc_sum >= {div_p1[7:0], 1'b0}) ? 9'h000 : acc_sum - div_p1;
        sck_q <= ~sck_q;
      end else if (src_tick) begin
        acc_q <= acc_sum;
      end
      if (sck_fall_gen) begin
        if (wcnt_q == word_phase_length) begin
          wcnt_q <= 5'h00;
          ws_q <= ~ws_q;
        end else begin
          wcnt_q <= wcnt_q + 5'h01;
        end
      end
    end
  end

  // Effective link lines; the engine sees its own clock in master mode.
  wire sck_eff = ms ? sck_q : sck_i;
  wire ws_eff = ms ? ws_q : ws_i;
  wire sck_rise = run && sck_eff && !sck_prev_q;
  wire sck_fall = run && !sck_eff && sck_prev_q;
  wire word_start = sck_fall && (ws_eff != ws_last_q);
  wire [5:0] bit_now = word_start ? 6'h00 : bit_q;

  // First bit position of the data inside a word phase.
  function [5:0] first_bit;
    input [1:0] fmt;
    input [4:0] wl;
    input [4:0] rl;
    begin
      if (fmt == `SSAP_FMT_STD) begin
        first_bit = 6'h01;
      end else if (fmt == `SSAP_FMT_RJ && wl > rl) begin
        first_bit = {1'b0, wl - rl};
      end else begin
        first_bit = 6'h00;
      end
    end
  endfunction

  wire [5:0] rx_first = first_bit(rx_fmt, word_phase_length, rx_res);
  wire [5:0] tx_first = first_bit(tx_fmt, word_phase_length, tx_res);
  // Between falls bit_q already holds the index of the next bit period, so the
  // receiver works on the period now running, which is one less.
  wire [5:0] bit_cur = bit_q - 6'h01;
  wire [5:0] rx_j = bit_cur - rx_first;
  wire [5:0] tx_j = bit_now - tx_first;
  wire rx_in = (bit_q > rx_first) && (rx_j <= {1'b0, rx_res});
  wire tx_in = (bit_now >= tx_first) && (tx_j <= {1'b0, tx_res});

  // Channel of the word now starting.
  wire left_now = (tx_fmt == `SSAP_FMT_STD) ? !ws_eff : ws_eff;
  wire left_rx = (rx_fmt == `SSAP_FMT_STD) ? !ws_eff : ws_eff;

  // Receive push of the finished word happens when the next word begins.
  wire rx_push = word_start && rx_have_q && (rx_fmt != `SSAP_FMT_OFF);
  wire rx_full_sel = rx_left_q ? rxl_full : rxr_full;
  wire rx_ovr = rx_push && rx_full_sel;

  // Transmit pop at word start; each channel drains whenever its FIFO is enabled.
  wire txl_en = txc_q[`SSAP_CTL_FENL];
  wire txr_en = txc_q[`SSAP_CTL_FENR];
  wire tx_pop_l = word_start && left_now && txl_en;
  wire tx_pop_r = word_start && !left_now && txr_en;
  wire tx_empty_sel = left_now ? txl_empty : txr_empty;
  wire tx_unr = word_start && (tx_fmt != `SSAP_FMT_OFF) && tx_empty_sel;
  wire [23:0] tx_head = left_now ? txl_head : txr_head;
  wire [23:0] tx_word = word_start ? (tx_empty_sel ? 24'h000000 : tx_head) : tx_sh_q;

  // Write alignment: narrow formats get their low bits padded.
  reg [23:0] tx_aligned;
  always @* begin
    if (txc_q[`SSAP_CTL_ALIGN] == `SSAP_AL_HI24) begin
      tx_aligned = wdata_i[31:8];
    end else if (txc_q[`SSAP_CTL_ALIGN] == `SSAP_AL_LO24) begin
      tx_aligned = wdata_i[23:0];
    end else if (txc_q[`SSAP_CTL_ALIGN] == `SSAP_AL_16) begin
      tx_aligned = {wdata_i[15:0], {8{fill}}};
    end else begin
      tx_aligned = {wdata_i[7:0], {16{fill}}};
    end
  end

  // Read alignment: wider received data loses its low bits.
  function [31:0] rx_align;
    input [1:0] al;
    input [23:0] d;
    begin
      if (al == `SSAP_AL_HI24) begin
        rx_align = {d, 8'h00};
      end else if (al == `SSAP_AL_LO24) begin
        rx_align = {8'h00, d};
      end else if (al == `SSAP_AL_16) begin
        rx_align = {16'h0000, d[23:8]};
      end else begin
        rx_align = {24'h000000, d[23:16]};
      end
    end
  endfunction

  // Serial engine.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_prev_q <= 1'b0;
      ws_last_q <= 1'b0;
      bit_q <= 6'h00;
      rx_sh_q <= 24'h000000;
      rx_left_q <= 1'b0;
      rx_have_q <= 1'b0;
      tx_sh_q <= 24'h000000;
      sdo_o <= 1'b0;
    end else if (run) begin
      sck_prev_q <= sck_eff;
      if (sck_fall) begin
        ws_last_q <= ws_eff;
        bit_q <= (bit_now == 6'h3F) ? bit_now : bit_now + 6'h01;
        tx_sh_q <= tx_word;
        if (tx_fmt != `SSAP_FMT_OFF && tx_in) begin
          sdo_o <= tx_word[5'd23 - tx_j[4:0]];
        end else begin
          sdo_o <= 1'b0;
        end
      end
      if (word_start) begin
        rx_sh_q <= 24'h000000;
        rx_left_q <= left_rx;
        rx_have_q <= 1'b1;
      end else if (sck_rise && rx_in) begin
        rx_sh_q[5'd23 - rx_j[4:0]] <= sdi_i;
      end
    end
  end

  ssap_fifo #(.W(24), .AW(AW)) u_rxl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .push_i(rx_push && rx_left_q), .wdata_i(rx_sh_q), .pop_i(rd_rxl),
    .head_o(rxl_head), .full_o(rxl_full), .empty_o(rxl_empty), .count_o(rxl_cnt)
  );
  ssap_fifo #(.W(24), .AW(AW)) u_rxr (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .push_i(rx_push && !rx_left_q), .wdata_i(rx_sh_q), .pop_i(rd_rxr),
    .head_o(rxr_head), .full_o(rxr_full), .empty_o(rxr_empty), .count_o(rxr_cnt)
  );
  ssap_fifo #(.W(24), .AW(AW)) u_txl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .push_i(wr_txl && txl_en), .wdata_i(tx_aligned), .pop_i(tx_pop_l),
    .head_o(txl_head), .full_o(txl_full), .empty_o(txl_empty), .count_o(txl_cnt)
  );
  ssap_fifo #(.W(24), .AW(AW)) u_txr (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .push_i(wr_txr && txr_en), .wdata_i(tx_aligned), .pop_i(tx_pop_r),
    .head_o(txr_head), .full_o(txr_full), .empty_o(txr_empty), .count_o(txr_cnt)
  );

  // Threshold conditions: free receive words or stored transmit words at or below
  // the programmed level.
  wire [AW:0] rx_thr = {{(AW-2){1'b0}}, rxc_q[`SSAP_CTL_THR]};
  wire [AW:0] tx_thr = {{(AW-2){1'b0}}, txc_q[`SSAP_CTL_THR]};
  wire [AW:0] full_cnt = DEPTH[AW:0];
  wire c_rxl = (full_cnt - rxl_cnt) <= rx_thr;
  wire c_rxr = (full_cnt - rxr_cnt) <= rx_thr;
  wire c_txl = txl_cnt <= tx_thr;
  wire c_txr = txr_cnt <= tx_thr;
  wire d_rxl = c_rxl && rxc_q[`SSAP_CTL_LD];
  wire d_rxr = c_rxr && rxc_q[`SSAP_CTL_RD];
  wire d_txl = c_txl && txc_q[`SSAP_CTL_LD];
  wire d_txr = c_txr && txc_q[`SSAP_CTL_RD];
  wire i_rxl = c_rxl && rxc_q[`SSAP_CTL_LI] && !rxc_q[`SSAP_CTL_LD];
  wire i_rxr = c_rxr && rxc_q[`SSAP_CTL_RI] && !rxc_q[`SSAP_CTL_RD];
  wire i_txl = c_txl && txc_q[`SSAP_CTL_LI] && !txc_q[`SSAP_CTL_LD];
  wire i_txr = c_txr && txc_q[`SSAP_CTL_RI] && !txc_q[`SSAP_CTL_RD];
  wire irq_d = i_rxl | i_rxr | i_txl | i_txr
    | (rxerr_q && rxc_q[`SSAP_CTL_ER])
    | (txerr_q && txc_q[`SSAP_CTL_ER]);

  wire [31:0] stat = {8'h00, txr_cnt, txl_cnt, rxr_cnt, rxl_cnt, 2'b00,
    i_txr, i_txl, i_rxr, i_rxl, txerr_q, rxerr_q};

  // Registers and read data.
  always @* begin
    rdata_d = 32'h00000000;
    if (addr_i == `SSAP_ADDR_CLK) begin
      rdata_d = clk_q;
    end else if (addr_i == `SSAP_ADDR_RXCTL) begin
      rdata_d = rxc_q;
    end else if (addr_i == `SSAP_ADDR_TXCTL) begin
      rdata_d = txc_q;
    end else if (addr_i == `SSAP_ADDR_RXL) begin
      rdata_d = rxl_empty ? 32'h00000000 : rx_align(rxc_q[`SSAP_CTL_ALIGN], rxl_head);
    end else if (addr_i == `SSAP_ADDR_RXR) begin
      rdata_d = rxr_empty ? 32'h00000000 : rx_align(rxc_q[`SSAP_CTL_ALIGN], rxr_head);
    end else if (addr_i == `SSAP_ADDR_STAT) begin
      rdata_d = stat;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_q <= `SSAP_CLK_RST;
      rxc_q <= `SSAP_CTL_RST;
      txc_q <= `SSAP_CTL_RST;
      rxerr_q <= 1'b0;
      txerr_q <= 1'b0;
      rdata_o <= 32'h00000000;
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      ws_o <= 1'b0;
      ws_oe_o <= 1'b0;
      irq_o <= 1'b0;
      dma_rxl_o <= 1'b0;
      dma_rxr_o <= 1'b0;
      dma_txl_o <= 1'b0;
      dma_txr_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_clk) begin
        if (ms) begin
          clk_q <= (clk_q & `SSAP_CLK_LOCKED) | (wdata_i & ~`SSAP_CLK_LOCKED & 32'h00000009);
        end else begin
          clk_q <= wdata_i & 32'h001FFF0F;
        end
      end
      if (wr_rxc) begin
        rxc_q <= wdata_i & `SSAP_RXCTL_MASK;
      end
      if (wr_txc) begin
        txc_q <= wdata_i & `SSAP_TXCTL_MASK;
      end
      // A new error in the cycle of a clear keeps the flag set.
      if (rx_ovr && run) begin
        rxerr_q <= 1'b1;
      end else if (wr_st && wdata_i[`SSAP_ST_RXERR]) begin
        rxerr_q <= 1'b0;
      end
      if (tx_unr && run) begin
        txerr_q <= 1'b1;
      end else if (wr_st && wdata_i[`SSAP_ST_TXERR]) begin
        txerr_q <= 1'b0;
      end
      if (rd_i) begin
        rdata_o <= rdata_d;
      end
      sck_o <= sck_q;
      ws_o <= ws_q;
      sck_oe_o <= ms && en;
      ws_oe_o <= ms && en;
      irq_o <= irq_d;
      dma_rxl_o <= d_rxl;
      dma_rxr_o <= d_rxr;
      dma_txl_o <= d_txl;
      dma_txr_o <= d_txr;
    end
  end
endmodule // ssap_top

// File: tb/ssap_codec.sv
`timescale 1ns/1ps
module ssap_codec #(
  parameter [7:0] LEFT_WORD = 8'h96,
  parameter [7:0] RIGHT_WORD = 8'h5A
) (
  input wire sck_i, // Bit clock from the port.
  input wire ws_i, // Word select from the port.
  input wire sdo_i, // Port serial output.
  output reg sdi_o, // Port serial input.
  output reg [7:0] cap_left_o, // First nonzero left word seen.
  output reg [7:0] cap_right_o // First nonzero right word seen.
);
  reg ws_prev;
  reg started;
  reg [7:0] tx_sh;
  reg [7:0] rx_sh;
  integer k;
  initial begin
    sdi_o = 1'b0;
    cap_left_o = 8'h00;
    cap_right_o = 8'h00;
    ws_prev = 1'b0;
    started = 1'b0;
    tx_sh = 8'h00;
    rx_sh = 8'h00;
    k = 0;
  end
  // Nothing counts until a real select toggle, so a partial first phase is never taken as a word.
  // Word select moves with the falling edge, so it is only looked at on the rising edge.
  always @(posedge sck_i) begin
    if (ws_i !== ws_prev) begin
      k = 0;
      started = 1'b1;
      tx_sh = ws_i ? RIGHT_WORD : LEFT_WORD;
    end else begin
      k = k + 1;
    end
    ws_prev = ws_i;
    if (started && k >= 1 && k <= 8) begin
      rx_sh = {rx_sh[6:0], sdo_i};
      if (k == 8 && rx_sh != 8'h00) begin
        if (ws_i && cap_right_o == 8'h00) cap_right_o <= rx_sh;
        if (!ws_i && cap_left_o == 8'h00) cap_left_o <= rx_sh;
      end
    end
  end
  // The fall that opens bit period k+1 follows the rise where k was counted.
  always @(negedge sck_i) begin
    if (started && k <= 7) begin
      sdi_o <= tx_sh[7];
      tx_sh = {tx_sh[6:0], 1'b0};
    end else begin
      sdi_o <= ~sdi_o;
    end
  end
endmodule // ssap_codec

// File: tb/ssap_top_properties.sv
`timescale 1ns/1ps
`include "ssap_defines.vh"
module ssap_props #(
  parameter AW = 3
) (
  input wire clk_i, // Bus clock.
  input wire rst_n_i, // Reset, active low.
  input wire ce_i, // Clock enable.
  input wire [23:0] addr_i, // Register address.
  input wire [31:0] wdata_i, // Write data.
  input wire wr_i, // Write strobe.
  input wire rd_i, // Read strobe.
  input wire [31:0] rdata_o, // Read data.
  input wire sck_o, // Bit clock out.
  input wire sck_oe_o, // Bit clock enable.
  input wire ws_o, // Word select out.
  input wire ws_oe_o, // Word select enable.
  input wire sdo_o // Serial data out.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reg ws_q;
  reg [1:0] seen_q;
  reg [15:0] cnt_q;
  reg [15:0] last_q;
  // The first phase after master select may be cut short, so two toggles pass before comparing.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ws_q <= 1'b0;
      seen_q <= 2'h0;
      cnt_q <= 16'h0000;
      last_q <= 16'h0000;
    end else if (!sck_oe_o) begin
      ws_q <= ws_o;
      seen_q <= 2'h0;
      cnt_q <= 16'h0000;
    end else if (ce_i) begin
      ws_q <= ws_o;
      if (ws_o != ws_q) begin
        last_q <= cnt_q;
        cnt_q <= 16'h0001;
        if (seen_q != 2'h2) seen_q <= seen_q + 2'h1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
  sequence master_req;
    wr_i && ce_i && addr_i == `SSAP_ADDR_CLK && wdata_i[3] && wdata_i[0];
  endsequence
  sequence slave_req;
    wr_i && ce_i && addr_i == `SSAP_ADDR_CLK && !wdata_i[3];
  endsequence
  master_drive_a: assert property (master_req ##1 ce_i |=> sck_oe_o)
    else $error("bit clock not driven after master select");
  slave_release_a: assert property (slave_req ##1 ce_i |=> !sck_oe_o && !ws_oe_o)
    else $error("pins still driven after slave select");
  oe_cause_a: assert property ($rose(sck_oe_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == `SSAP_ADDR_CLK)
    else $error("bit clock enabled without a clock register write");
  pins_paired_a: assert property (sck_oe_o == ws_oe_o)
    else $error("bit clock and word select enables differ");
  ws_on_fall_a: assert property ($changed(ws_o) && sck_oe_o && $past(sck_oe_o) |-> $fell(sck_o))
    else $error("word select moved away from a bit clock fall");
  phase_equal_a: assert property (ws_o != ws_q && seen_q == 2'h2 && sck_oe_o |-> cnt_q == last_q)
    else $error("word select phases of unequal length");
  freeze_out_a: assert property (!ce_i |=> $stable(sck_o) && $stable(ws_o) && $stable(sdo_o))
    else $error("port outputs moved while clock enable low");
  unmapped_zero_a: assert property (rd_i && ce_i && addr_i > `SSAP_ADDR_STAT |=> rdata_o == 32'h0)
    else $error("unmapped read returned nonzero data");
endmodule // ssap_props

bind ssap_top ssap_props #(.AW(AW)) u_ssap_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
  .ws_o(ws_o), .ws_oe_o(ws_oe_o), .sdo_o(sdo_o)
);

// File: tb/test_ssap_top.sv
`timescale 1ns/1ps
`include "ssap_defines.vh"
module test_ssap_top;
  reg clk_i, rst_n_i, ce_i, aux_tick_i, wr_i, rd_i;
  reg [23:0] addr_i;
  reg [31:0] wdata_i;
  reg [31:0] rd_data;
  wire [31:0] rdata_o;
  wire sck_o, sck_oe_o, ws_o, ws_oe_o, sdo_o, sdi_w, irq_o, sck_w, ws_w;
  wire dma_rxl_o, dma_rxr_o, dma_txl_o, dma_txr_o;
  wire [7:0] cap_left, cap_right;
  integer err_count, total_checks, i;
  // No other master sits on the pins, so they idle low while the port is a slave.
  assign sck_w = sck_oe_o ? sck_o : 1'b0;
  assign ws_w = ws_oe_o ? ws_o : 1'b0;
  ssap_top u_ssap_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .aux_tick_i(aux_tick_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ws_i(ws_w), .ws_o(ws_o),
    .ws_oe_o(ws_oe_o), .sdi_i(sdi_w), .sdo_o(sdo_o), .irq_o(irq_o), .dma_rxl_o(dma_rxl_o),
    .dma_rxr_o(dma_rxr_o), .dma_txl_o(dma_txl_o), .dma_txr_o(dma_txr_o)
  );
  ssap_codec #(.LEFT_WORD(8'h96), .RIGHT_WORD(8'h5A)) u_ssap_codec (
    .sck_i(sck_w), .ws_i(ws_w), .sdo_i(sdo_o), .sdi_o(sdi_w),
    .cap_left_o(cap_left), .cap_right_o(cap_right)
  );
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task wrap_up;
    begin
      $display("counts: %0d checks, %0d mismatches", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected %0s: expected %h, seen %h", name, exp, got);
      end
    end
  endtask
  task reg_wr(input [23:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd_chk(input [8*12-1:0] name, input [23:0] a, input [31:0] mask, input [31:0] exp);
    begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rd_data = rdata_o;
      chk(name, exp, rd_data & mask);
    end
  endtask
  // Order is irq, rx left, rx right, tx left, tx right.
  task flags(input [4:0] exp);
    begin
      repeat (3) @(posedge clk_i);
      #1 chk("requests", {27'h0, exp}, {27'h0, irq_o, dma_rxl_o, dma_rxr_o, dma_txl_o, dma_txr_o});
    end
  endtask
  // Counts changes of the bit clock output over a number of bus clock cycles.
  task toggles(input [8*12-1:0] name, input integer cycles, input [31:0] exp);
    reg last;
    integer n;
    begin
      n = 0;
      #1 last = sck_o;
      repeat (cycles) begin
        @(posedge clk_i);
        #1 if (sck_o !== last) n = n + 1;
        last = sck_o;
      end
      chk(name, exp, n);
    end
  endtask
  task wait_for(input integer sel);
    begin
      for (i = 0; i < 4000 && !(sel == 0 ? (cap_left != 8'h00 && cap_right != 8'h00)
          : dma_rxl_o === 1'b1); i = i + 1) @(posedge clk_i);
      if (i == 4000) begin
        err_count = err_count + 1;
        $display("unexpected wait_done %0d: expected 1, seen 0", sel);
        wrap_up;
      end
    end
  endtask
  initial begin
    err_count = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    aux_tick_i = 1'b1;
    addr_i = 24'h000000;
    wdata_i = 32'h00000000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk("clk_reg", `SSAP_ADDR_CLK, 32'hFFFFFFFF, 32'h00070000);
    rd_chk("rx_ctl", `SSAP_ADDR_RXCTL, 32'hFFFFFFFF, 32'h0000001C);
    rd_chk("tx_ctl", `SSAP_ADDR_TXCTL, 32'hFFFFFFFF, 32'h0000001C);
    rd_chk("unmapped", 24'hFF4020, 32'hFFFFFFFF, 32'h00000000);
    $display("test reset_values done");
    reg_wr(`SSAP_ADDR_TXCTL, 32'h0000C81D);
    reg_wr(`SSAP_ADDR_TXL, 32'h000000FF);
    reg_wr(`SSAP_ADDR_TXCTL, 32'h0000F81D);
    flags(5'h02);
    reg_wr(`SSAP_ADDR_TXL, 32'h000000A5);
    reg_wr(`SSAP_ADDR_TXR, 32'h0000003C);
    rd_chk("fifo_counts", `SSAP_ADDR_STAT, 32'h00FF0000, 32'h00110000);
    flags(5'h00);
    $display("test prefill done");
    reg_wr(`SSAP_ADDR_RXCTL, 32'h0000C81D);
    reg_wr(`SSAP_ADDR_CLK, 32'h00080F01);
    reg_wr(`SSAP_ADDR_CLK, 32'h00080F09);
    reg_wr(`SSAP_ADDR_CLK, 32'h00050709);
    rd_chk("clk_reg", `SSAP_ADDR_CLK, 32'hFFFFFFFF, 32'h00080F09);
    chk("bit_clock_oe", 32'h1, {31'h0, sck_oe_o});
    $display("test master_setup done");
    repeat (100) @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    ce_i <= 1'b1;
    wait_for(0);
    chk("left_sent", 32'h000000A5, {24'h0, cap_left});
    chk("right_sent", 32'h0000003C, {24'h0, cap_right});
    wait_for(1);
    repeat (300) @(posedge clk_i);
    rd_chk("error_flags", `SSAP_ADDR_STAT, 32'h00000003, 32'h00000003);
    flags(5'h0A);
    reg_wr(`SSAP_ADDR_RXCTL, 32'h0000C91D);
    flags(5'h1A);
    $display("test streaming done");
    reg_wr(`SSAP_ADDR_RXCTL, 32'h0000C91C);
    reg_wr(`SSAP_ADDR_TXCTL, 32'h0000F81C);
    rd_chk("left_word", `SSAP_ADDR_RXL, 32'hFFFFFFFF, 32'h00000096);
    rd_chk("right_word", `SSAP_ADDR_RXR, 32'hFFFFFFFF, 32'h0000005A);
    flags(5'h02);
    reg_wr(`SSAP_ADDR_STAT, 32'h00000003);
    rd_chk("error_flags", `SSAP_ADDR_STAT, 32'h00000003, 32'h00000000);
    reg_wr(`SSAP_ADDR_CLK, 32'h00080F01);
    repeat (2) @(posedge clk_i);
    #1 chk("bit_clock_oe", 32'h0, {31'h0, sck_oe_o});
    $display("test unload done");
    reg_wr(`SSAP_ADDR_CLK, 32'h00080F03);
    aux_tick_i <= 1'b0;
    reg_wr(`SSAP_ADDR_CLK, 32'h00080F0B);
    toggles("aux_stopped", 40, 32'h0);
    @(posedge clk_i);
    aux_tick_i <= 1'b1;
    toggles("aux_running", 41, 32'hA);
    $display("test aux_source done");
    wrap_up;
  end
endmodule // test_ssap_top
